/* File: design/ddc_core.sv */
// Synthesizer core: profile and mode control, accumulators, sample FIFO
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------------
module ddc_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic in_valid, // Write request
    output logic in_ready, // Room available
    input wire logic [WIDTH-1:0] in_data, // Write data
    output logic out_valid, // Data available
    input wire logic out_ready, // Read acknowledge
    output logic [WIDTH-1:0] out_data // Head of queue
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] count;
    } ddc_fifo_state_t;

    ddc_fifo_state_t s;
    ddc_fifo_state_t next_s;
    logic do_wr;
    logic do_rd;

    assign in_ready = (s.count != (AW+1)'(DEPTH));
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rptr];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (do_wr) begin
            next_s.mem[s.wptr] = in_data;
            next_s.wptr = (s.wptr == AW'(DEPTH - 1)) ? '0 : s.wptr + 1'b1;
        end
        if (do_rd) begin
            next_s.rptr = (s.rptr == AW'(DEPTH - 1)) ? '0 : s.rptr + 1'b1;
        end
        if (do_wr && !do_rd) begin
            next_s.count = s.count + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // ddc_fifo

// ----------------------------------------------------------------------
// Core top
// ----------------------------------------------------------------------
module ddc_core #(
    parameter int FIFO_DEPTH = 32,
    parameter int DAC_WIDTH = 10
) (
    input wire logic MCLK, // System sample clock
    input wire logic RESETN, // Asynchronous reset, active low
    input wire logic REG_WR, // Register write strobe
    input wire logic REG_RD, // Register read strobe
    input wire logic [7:0] REG_ADDR, // Register index
    input wire logic [63:0] REG_WDATA, // Write data, low aligned
    output logic [63:0] REG_RDATA, // Read data
    output logic REG_RVALID, // Read data valid pulse
    input wire logic IO_UPDATE, // Update strobe pin
    input wire logic [2:0] PROFILE_SELECT_PINS, // External profile code
    input wire logic PORT_TYPE_SELECT, // Low serial, high parallel
    output logic SYNC_CLK, // Divided clock for pin timing
    output logic [DAC_WIDTH-1:0] DAC_DATA, // Converter sample, offset binary
    output logic DAC_VALID, // Sample valid
    input wire logic DAC_READY // Converter takes sample
);
    // ------------------------------------------------------------------
    // Angle to amplitude: parabolic half-wave shape per half cycle
    // ------------------------------------------------------------------
    function automatic logic [DAC_WIDTH-1:0] ddc_amplitude(input logic [13:0] ang);
        logic [12:0] x;
        logic [25:0] prod;
        logic [8:0] mag;
        x = ang[12:0];
        prod = 26'(x) * 26'(14'h2000 - 14'(x));
        if (prod[24]) begin
            // Exact peak overflows the magnitude field; clamp to full scale
            mag = 9'h1FF;
        end else begin
            mag = prod[23:15];
        end
        return ang[13] ? ddc_pkg::DAC_MIDSCALE - 10'(mag)
                       : ddc_pkg::DAC_MIDSCALE + 10'(mag);
    endfunction

    localparam int DIVW = $clog2(ddc_pkg::SYNC_CLK_DIV);

    typedef struct packed {
        logic [31:0] buf_ctl;
        logic [31:0] buf_ftw;
        logic [13:0] buf_pow;
        logic [63:0] buf_bx;
        logic [31:0] buf_a;
        logic [31:0] ctl;
        logic [31:0] freq_tuning_word;
        logic [13:0] phase_offset_word;
        logic [63:0] bx;
        logic [31:0] a;
        logic [7:0][45:0] prof;
        logic [2:0] int_profile;
        logic [2:0] profile;
        logic [1:0][2:0] pin_sync;
        logic [1:0] upd_sync;
        logic [1:0] par_sync;
        logic upd_prev;
        logic [31:0] phase;
        logic [31:0] aux;
        logic [DIVW-1:0] div;
        logic sync_clk;
        logic [63:0] rdata;
        logic rvalid;
        logic [DAC_WIDTH-1:0] dac_data;
        logic dac_valid;
    } ddc_state_t;

    ddc_state_t s;
    ddc_state_t next_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DAC_WIDTH-1:0] fifo_out_data;
    logic [DAC_WIDTH-1:0] sample;
    logic update;
    logic use_internal;
    logic direct_mode;
    logic modulus_mode;
    logic [1:0] dest;
    logic [31:0] step;
    logic [13:0] offset;
    logic [32:0] aux_sum;
    logic carry;
    logic [13:0] angle;
    logic [2:0] prof_idx;

    // ------------------------------------------------------------------
    // Mode and profile decode
    // ------------------------------------------------------------------
    assign update = s.upd_sync[1] && !s.upd_prev;
    assign use_internal = s.par_sync[1] || s.ctl[ddc_pkg::CTL_SOURCE_BIT];
    assign direct_mode = s.ctl[ddc_pkg::CTL_DIRECT_BIT];
    assign modulus_mode = s.ctl[ddc_pkg::CTL_AUX_EN_BIT] && !direct_mode;
    assign dest = s.ctl[ddc_pkg::CTL_DEST_LSB +: 2];
    assign fifo_out_ready = !s.dac_valid || DAC_READY;

    always_comb begin
        step = s.freq_tuning_word;
        offset = s.phase_offset_word;
        if (direct_mode) begin
            if (dest == ddc_pkg::DEST_FREQ) begin
                step = s.prof[s.profile][31:0];
            end else if (dest == ddc_pkg::DEST_PHASE) begin
                offset = s.prof[s.profile][ddc_pkg::PROF_POW_LSB +: 14];
            end
        end else if (modulus_mode) begin
            step = s.bx[63:32];
        end
    end

    // Auxiliary accumulator wraps at X; each wrap is one extra phase LSB
    assign aux_sum = {1'b0, s.aux} + {1'b0, s.a};
    assign carry = modulus_mode && (aux_sum >= {1'b0, s.bx[31:0]});

    // Offset joins the phase ahead of amplitude conversion
    assign angle = s.phase[31:18] + offset
                   + (s.ctl[ddc_pkg::CTL_SINE_BIT] ? 14'h0000 : ddc_pkg::QUARTER_TURN);
    assign sample = ddc_amplitude(angle);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        prof_idx = REG_ADDR[2:0] - ddc_pkg::ADDR_PROFILE_BASE[2:0];
        // Pin synchronisers
        next_s.pin_sync[0] = PROFILE_SELECT_PINS;
        next_s.pin_sync[1] = s.pin_sync[0];
        next_s.upd_sync = {s.upd_sync[0], IO_UPDATE};
        next_s.par_sync = {s.par_sync[0], PORT_TYPE_SELECT};
        next_s.upd_prev = s.upd_sync[1];
        // Sync clock output
        if (s.div == DIVW'(ddc_pkg::SYNC_CLK_DIV / 2 - 1)) begin
            next_s.div = '0;
            next_s.sync_clk = !s.sync_clk;
        end else begin
            next_s.div = s.div + 1'b1;
        end
        // Register writes land in the buffers, profiles directly
        if (REG_WR) begin
            if (REG_ADDR == ddc_pkg::ADDR_CONTROL_ONE) begin
                next_s.buf_ctl = REG_WDATA[31:0];
            end else if (REG_ADDR == ddc_pkg::ADDR_FREQ_TUNING) begin
                next_s.buf_ftw = REG_WDATA[31:0];
            end else if (REG_ADDR == ddc_pkg::ADDR_PHASE_OFFSET) begin
                next_s.buf_pow = REG_WDATA[13:0];
            end else if (REG_ADDR == ddc_pkg::ADDR_MODULUS_BX) begin
                next_s.buf_bx = REG_WDATA;
            end else if (REG_ADDR == ddc_pkg::ADDR_MODULUS_A) begin
                next_s.buf_a = REG_WDATA[31:0];
            end else if (REG_ADDR >= ddc_pkg::ADDR_PROFILE_BASE
                         && REG_ADDR <= ddc_pkg::ADDR_PROFILE_LAST) begin
                next_s.prof[prof_idx] = REG_WDATA[45:0];
            end
        end
        // Update moves buffers into the active set
        if (update) begin
            next_s.ctl = s.buf_ctl;
            next_s.freq_tuning_word = s.buf_ftw;
            next_s.phase_offset_word = s.buf_pow;
            next_s.bx = s.buf_bx;
            next_s.a = s.buf_a;
            next_s.int_profile = s.buf_ctl[ddc_pkg::CTL_PROFILE_LSB +: 3];
        end
        // Profile code registered each clock from the chosen source
        next_s.profile = use_internal ? s.int_profile : s.pin_sync[1];
        // Accumulators step when the FIFO accepts a sample
        if (fifo_in_ready) begin
            next_s.phase = s.phase + step + {31'h0000_0000, carry};
            if (!modulus_mode) begin
                next_s.aux = 32'h0000_0000;
            end else if (carry) begin
                next_s.aux = 32'(aux_sum - {1'b0, s.bx[31:0]});
            end else begin
                next_s.aux = aux_sum[31:0];
            end
        end
        // Register reads
        next_s.rvalid = REG_RD;
        if (REG_RD) begin
            if (REG_ADDR == ddc_pkg::ADDR_CONTROL_ONE) begin
                next_s.rdata = {32'h0000_0000, s.ctl};
            end else if (REG_ADDR == ddc_pkg::ADDR_FREQ_TUNING) begin
                next_s.rdata = {32'h0000_0000, s.freq_tuning_word};
            end else if (REG_ADDR == ddc_pkg::ADDR_PHASE_OFFSET) begin
                next_s.rdata = {50'h0, s.phase_offset_word};
            end else if (REG_ADDR == ddc_pkg::ADDR_MODULUS_BX) begin
                next_s.rdata = s.bx;
            end else if (REG_ADDR == ddc_pkg::ADDR_MODULUS_A) begin
                next_s.rdata = {32'h0000_0000, s.a};
            end else if (REG_ADDR >= ddc_pkg::ADDR_PROFILE_BASE
                         && REG_ADDR <= ddc_pkg::ADDR_PROFILE_LAST) begin
                next_s.rdata = {18'h0, s.prof[prof_idx]};
            end else if (REG_ADDR == ddc_pkg::ADDR_STATUS) begin
                next_s.rdata = {26'h0, s.profile, modulus_mode, direct_mode, 1'b0, s.phase};
            end else begin
                next_s.rdata = 64'h0000_0000_0000_0000;
            end
        end
        // Output stage toward the converter
        if (fifo_out_ready) begin
            next_s.dac_valid = fifo_out_valid;
            next_s.dac_data = fifo_out_data;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= '0;
            s.buf_ctl <= ddc_pkg::RST_CONTROL_ONE;
            s.buf_ftw <= ddc_pkg::RST_FREQ_TUNING;
            s.buf_pow <= ddc_pkg::RST_PHASE_OFFSET;
            s.buf_bx <= ddc_pkg::RST_MODULUS_BX;
            s.buf_a <= ddc_pkg::RST_MODULUS_A;
            s.ctl <= ddc_pkg::RST_CONTROL_ONE;
            s.freq_tuning_word <= ddc_pkg::RST_FREQ_TUNING;
            s.phase_offset_word <= ddc_pkg::RST_PHASE_OFFSET;
            s.bx <= ddc_pkg::RST_MODULUS_BX;
            s.a <= ddc_pkg::RST_MODULUS_A;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Sample FIFO and outputs
    // ------------------------------------------------------------------
    ddc_fifo #(
        .WIDTH(DAC_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RESETN),
        .in_valid(1'b1),
        .in_ready(fifo_in_ready),
        .in_data(sample),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    assign REG_RDATA = s.rdata;
    assign REG_RVALID = s.rvalid;
    assign SYNC_CLK = s.sync_clk;
    assign DAC_DATA = s.dac_data;
    assign DAC_VALID = s.dac_valid;
endmodule // ddc_core

`default_nettype wire

/* File: design/ddc_pkg.sv */
// Shared constants for the synthesizer core: register indices, fields, resets
package ddc_pkg;
    // ------------------------------------------------------------------
    // Register indices on the register write and read ports
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL_ONE = 8'h00;
    localparam logic [7:0] ADDR_FREQ_TUNING = 8'h03;
    localparam logic [7:0] ADDR_PHASE_OFFSET = 8'h04;
    localparam logic [7:0] ADDR_MODULUS_BX = 8'h06;
    localparam logic [7:0] ADDR_MODULUS_A = 8'h07;
    localparam logic [7:0] ADDR_PROFILE_BASE = 8'h09;
    localparam logic [7:0] ADDR_PROFILE_LAST = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    // ------------------------------------------------------------------
    // Field positions of the first control register
    // ------------------------------------------------------------------
    localparam int CTL_SINE_BIT = 0;
    localparam int CTL_AUX_EN_BIT = 11;
    localparam int CTL_DEST_LSB = 12;
    localparam int CTL_DIRECT_BIT = 16;
    localparam int CTL_PROFILE_LSB = 20;
    localparam int CTL_SOURCE_BIT = 27;
    localparam logic [1:0] DEST_FREQ = 2'h0;
    localparam logic [1:0] DEST_PHASE = 2'h1;
    // ------------------------------------------------------------------
    // Profile word layout: tuning word low, phase offset above it
    // ------------------------------------------------------------------
    localparam int PROF_POW_LSB = 32;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_CONTROL_ONE = 32'h0000_0000;
    localparam logic [31:0] RST_FREQ_TUNING = 32'h0000_0000;
    localparam logic [13:0] RST_PHASE_OFFSET = 14'h0000;
    localparam logic [63:0] RST_MODULUS_BX = 64'h0000_0000_0000_0000;
    localparam logic [31:0] RST_MODULUS_A = 32'h0000_0000;
    // ------------------------------------------------------------------
    // Timing and datapath constants
    // ------------------------------------------------------------------
    localparam int SYNC_CLK_DIV = 4;
    localparam logic [13:0] QUARTER_TURN = 14'h1000;
    localparam logic [9:0] DAC_MIDSCALE = 10'h200;
endpackage

/* File: dv/ddc_far_side.sv */
// Far-side model: converter sample sink and profile pin driver
`timescale 1ns/1ps
`default_nettype none
module ddc_far_side (
    input wire logic mclk, // Clock
    input wire logic sync_clk, // Pin timing reference
    input wire logic stall, // Hold off the converter
    input wire logic slow, // Take every other sample
    input wire logic [2:0] want_code, // Requested profile code
    output logic dac_ready, // Sample taken
    output logic [2:0] pins // Profile code pins
);
    logic phase = 1'b0;
    logic sync_seen = 1'b0;
    initial dac_ready = 1'b0;
    initial pins = 3'h0;
    always @(negedge mclk) begin
        phase <= ~phase;
        dac_ready <= !stall && (!slow || phase);
        sync_seen <= sync_clk;
        // Launch a new code just after a sync rise, set up for the next one
        if (sync_clk && !sync_seen) begin
            pins <= want_code;
        end
    end
endmodule // ddc_far_side
`default_nettype wire

/* File: dv/ddc_props.sv */
// Port checker for the synthesizer core
`timescale 1ns/1ps
`default_nettype none
module ddc_props #(
    parameter int FIFO_DEPTH = 32,
    parameter int DAC_WIDTH = 10
) (
    input wire logic MCLK, // Clock
    input wire logic RESETN, // Reset, active low
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    input wire logic [7:0] REG_ADDR, // Register index
    input wire logic [63:0] REG_WDATA, // Write data
    input wire logic [63:0] REG_RDATA, // Read data
    input wire logic REG_RVALID, // Read answer
    input wire logic IO_UPDATE, // Update strobe
    input wire logic [2:0] PROFILE_SELECT_PINS, // Profile pins
    input wire logic PORT_TYPE_SELECT, // Port type
    input wire logic SYNC_CLK, // Divided clock
    input wire logic [DAC_WIDTH-1:0] DAC_DATA, // Sample
    input wire logic DAC_VALID, // Sample valid
    input wire logic DAC_READY // Sample taken
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    a_read_answer: assert property (REG_RD |=> REG_RVALID)
        else $error("read not answered next cycle");
    a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD))
        else $error("read answer without request");
    a_data_held: assert property (!$past(REG_RD) |-> $stable(REG_RDATA))
        else $error("read data moved without a read");
    a_modes_exclusive: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h20
        |-> !(REG_RDATA[33] && REG_RDATA[34])) else $error("two modes active");
    a_offset_width: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h04
        |-> REG_RDATA[63:14] == 50'h0) else $error("offset wider than 14 bits");
    a_delta_width: assert property ($past(REG_RD) && $past(REG_ADDR) == 8'h07
        |-> REG_RDATA[63:32] == 32'h0) else $error("delta word upper half set");
    a_sample_held: assert property (DAC_VALID && !DAC_READY
        |=> DAC_VALID && $stable(DAC_DATA)) else $error("sample dropped while stalled");
    a_sync_shape: assert property ($rose(SYNC_CLK) |-> SYNC_CLK ##1 SYNC_CLK
        ##1 !SYNC_CLK ##1 !SYNC_CLK ##1 SYNC_CLK) else $error("sync clock not two high two low");
endmodule // ddc_props
`default_nettype wire

/* File: dv/ddc_tb.sv */
// Self-checking bench for the synthesizer core
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [63:0] reg_wdata = 64'h0;
    logic [63:0] reg_rdata;
    logic reg_rvalid;
    logic io_update = 1'b0;
    logic [2:0] pins;
    logic port_type = 1'b0;
    logic sync_clk;
    logic [9:0] dac_data;
    logic dac_valid;
    logic dac_ready;
    logic stall = 1'b0;
    logic slow = 1'b0;
    logic [2:0] want_code = 3'h0;
    logic [63:0] rd_val;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    ddc_core #(.FIFO_DEPTH(32), .DAC_WIDTH(10)) DUT (.MCLK(mclk), .RESETN(resetn),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .IO_UPDATE(io_update),
        .PROFILE_SELECT_PINS(pins), .PORT_TYPE_SELECT(port_type), .SYNC_CLK(sync_clk),
        .DAC_DATA(dac_data), .DAC_VALID(dac_valid), .DAC_READY(dac_ready));
    ddc_far_side u_far (.mclk(mclk), .sync_clk(sync_clk), .stall(stall), .slow(slow),
        .want_code(want_code), .dac_ready(dac_ready), .pins(pins));
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    // ------------
    // Bus and compare tasks
    // ------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [63:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        check({63'h0, reg_rvalid}, 64'h1);
        rd_val = reg_rdata;
        reg_rd = 1'b0;
    endtask
    task automatic upd();
        @(negedge mclk);
        io_update = 1'b1;
        repeat (3) @(negedge mclk);
        io_update = 1'b0;
        repeat (8) @(negedge mclk);
    endtask
    task automatic step_chk(input int gap, input logic [31:0] exp);
        logic [31:0] ph0;
        rd(ddc_pkg::ADDR_STATUS);
        ph0 = rd_val[31:0];
        repeat (gap - 2) @(negedge mclk);
        rd(ddc_pkg::ADDR_STATUS);
        check({32'h0, rd_val[31:0] - ph0}, {32'h0, exp});
    endtask
    task automatic prof_chk(input logic [2:0] exp);
        rd(ddc_pkg::ADDR_STATUS);
        check({61'h0, rd_val[37:35]}, {61'h0, exp});
    endtask
    // ------------
    // Scenarios
    // ------------
    task automatic t_reset();
        rd(ddc_pkg::ADDR_CONTROL_ONE);
        check(rd_val, {32'h0, ddc_pkg::RST_CONTROL_ONE});
        rd(ddc_pkg::ADDR_STATUS);
        check({59'h0, rd_val[37:33]}, 64'h0);
        rd(8'h55);
        check(rd_val, 64'h0);
        check({54'h0, dac_data}, {54'h0, ddc_pkg::DAC_MIDSCALE + 10'h1FF});
        wr(ddc_pkg::ADDR_CONTROL_ONE, 64'h1 << ddc_pkg::CTL_SINE_BIT);
        upd();
        check({54'h0, dac_data}, {54'h0, ddc_pkg::DAC_MIDSCALE});
    endtask
    task automatic t_tone();
        wr(ddc_pkg::ADDR_FREQ_TUNING, 64'h7FFF_FFFF);
        wr(ddc_pkg::ADDR_PHASE_OFFSET, 64'h3ABC);
        rd(ddc_pkg::ADDR_FREQ_TUNING);
        check(rd_val, 64'h0);
        upd();
        rd(ddc_pkg::ADDR_FREQ_TUNING);
        check(rd_val, 64'h7FFF_FFFF);
        rd(ddc_pkg::ADDR_PHASE_OFFSET);
        check(rd_val, 64'h3ABC);
        step_chk(2, 32'hFFFF_FFFE);
    endtask
    task automatic t_direct();
        for (int n = 0; n < 8; n++) begin
            wr(ddc_pkg::ADDR_PROFILE_BASE + 8'(n), {32'h0, 32'h0010_0000 * 32'(n + 1)});
        end
        wr(ddc_pkg::ADDR_CONTROL_ONE, 64'h1 << ddc_pkg::CTL_DIRECT_BIT);
        upd();
        for (int n = 0; n < 8; n++) begin
            want_code = 3'(n);
            repeat (12) @(negedge mclk);
            prof_chk(3'(n));
            check({63'h0, rd_val[33]}, 64'h1);
            step_chk(2, 32'h0020_0000 * 32'(n + 1));
        end
        port_type = 1'b1;
        repeat (8) @(negedge mclk);
        prof_chk(3'h0);
        port_type = 1'b0;
    endtask
    task automatic t_internal();
        wr(ddc_pkg::ADDR_CONTROL_ONE, (64'h1 << ddc_pkg::CTL_DIRECT_BIT)
            | (64'h1 << ddc_pkg::CTL_SOURCE_BIT) | (64'h5 << ddc_pkg::CTL_PROFILE_LSB));
        repeat (8) @(negedge mclk);
        prof_chk(3'h7);
        upd();
        prof_chk(3'h5);
        want_code = 3'h2;
        repeat (12) @(negedge mclk);
        prof_chk(3'h5);
    endtask
    task automatic t_modulus();
        wr(ddc_pkg::ADDR_MODULUS_BX, 64'h0000_0100_0000_0004);
        wr(ddc_pkg::ADDR_MODULUS_A, 64'h1);
        wr(ddc_pkg::ADDR_CONTROL_ONE, 64'h1 << ddc_pkg::CTL_AUX_EN_BIT);
        upd();
        rd(ddc_pkg::ADDR_MODULUS_BX);
        check(rd_val, 64'h0000_0100_0000_0004);
        rd(ddc_pkg::ADDR_MODULUS_A);
        check(rd_val, 64'h1);
        rd(ddc_pkg::ADDR_STATUS);
        check({62'h0, rd_val[34:33]}, 64'h2);
        step_chk(4, 32'h0000_0401);
        wr(ddc_pkg::ADDR_CONTROL_ONE, 64'h1_0800);
        upd();
        rd(ddc_pkg::ADDR_STATUS);
        check({62'h0, rd_val[34:33]}, 64'h1);
    endtask
    task automatic t_stall();
        stall = 1'b1;
        repeat (60) @(negedge mclk);
        check({63'h0, dac_valid}, 64'h1);
        step_chk(4, 32'h0);
        slow = 1'b1;
        stall = 1'b0;
        repeat (20) @(negedge mclk);
        step_chk(4, 32'h0060_0000);
        slow = 1'b0;
    endtask
    task automatic t_phase();
        logic [9:0] d0;
        wr(ddc_pkg::ADDR_FREQ_TUNING, 64'h0);
        wr(ddc_pkg::ADDR_PROFILE_BASE + 8'h01, 64'h2000 << ddc_pkg::PROF_POW_LSB);
        wr(ddc_pkg::ADDR_CONTROL_ONE, (64'h1 << ddc_pkg::CTL_DIRECT_BIT)
            | (64'(ddc_pkg::DEST_PHASE) << ddc_pkg::CTL_DEST_LSB));
        upd();
        want_code = 3'h0;
        repeat (48) @(negedge mclk);
        d0 = dac_data;
        want_code = 3'h1;
        repeat (48) @(negedge mclk);
        check(64'(dac_data) + 64'(d0), 2 * 64'(ddc_pkg::DAC_MIDSCALE));
    endtask
    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        resetn = 1'b1;
        t_reset();
        t_tone();
        t_direct();
        t_internal();
        t_modulus();
        t_stall();
        t_phase();
        print_verdict();
    end
endmodule // testbench
bind ddc_core ddc_props #(.FIFO_DEPTH(FIFO_DEPTH), .DAC_WIDTH(DAC_WIDTH)) u_props (
    .MCLK(MCLK), .RESETN(RESETN), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .IO_UPDATE(IO_UPDATE), .PROFILE_SELECT_PINS(PROFILE_SELECT_PINS),
    .PORT_TYPE_SELECT(PORT_TYPE_SELECT), .SYNC_CLK(SYNC_CLK), .DAC_DATA(DAC_DATA),
    .DAC_VALID(DAC_VALID), .DAC_READY(DAC_READY));
`default_nettype wire
